/* File: hpep_ctrl.sv */
// Host controller driving the time processor's 16-byte I/O page
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module hpep_ctrl
    import hpep_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    output logic [3:0] DEV_A_OUT,
    input wire logic [7:0] DEV_D_IN,
    output logic [7:0] DEV_D_OUT,
    output logic DEV_D_OE_OUT,
    output logic DEV_RD_N_OUT,
    output logic DEV_WR_N_OUT
);
    hpep_st_t s_reg;
    hpep_st_t s_next;
    logic [7:0] d_meta_reg;
    logic [7:0] d_sync_reg;
    logic [7:0] data_reg [0:EVENT_REG_COUNT-1];
    logic data_we;
    logic [3:0] data_idx;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // Packet byte for current step
    function automatic logic [7:0] pkt_byte(input logic [7:0] cmd, input logic [3:0] step,
                                            input logic [7:0] a0, input logic [7:0] a1,
                                            input logic [7:0] a2);
        logic [7:0] id;
        logic [7:0] b [0:3];
        id = (cmd == CMD_GAIN) ? ID_GAIN : ((cmd == CMD_OFFSET) ? ID_OFFSET : ID_MODE);
        b[0] = 8'h00;
        b[1] = 8'h00;
        b[2] = 8'h00;
        b[3] = 8'h00;
        if (cmd == CMD_GAIN) begin
            b[0] = hex_char(a0[3:0]);
            b[1] = hex_char(a0[7:4]);
            b[2] = a1[0] ? 8'h31 : 8'h30;
        end else if (cmd == CMD_OFFSET) begin
            b[0] = a1[0] ? 8'h2d : 8'h2b;
            b[1] = 8'h30 + {4'h0, a0[7:4]};
            b[2] = 8'h30 + {4'h0, a0[3:0]};
        end else begin
            b[0] = a0[0] ? 8'h31 : 8'h30;
        end
        if (step == 4'h0) begin
            pkt_byte = PACKET_START_BYTE;
        end else if (step == 4'h1) begin
            pkt_byte = id;
        end else if (step == 4'h2) begin
            pkt_byte = b[0];
        end else if (step == 4'h3) begin
            pkt_byte = b[1];
        end else if (step == 4'h4) begin
            pkt_byte = b[2];
        end else begin
            pkt_byte = b[3];
        end
    endfunction

    always_ff @(posedge CLK_IN) begin
        d_meta_reg <= DEV_D_IN;
        d_sync_reg <= d_meta_reg;
    end

    always_comb begin
        s_next = s_reg;
        data_we = 1'b0;
        data_idx = 4'h0;
        if (WR_IN && !s_reg.busy) begin
            if (ADDR_IN == C_ARG0) begin
                s_next.arg0 = WDATA_IN;
            end else if (ADDR_IN == C_ARG1) begin
                s_next.arg1 = WDATA_IN;
            end else if (ADDR_IN == C_ARG2) begin
                s_next.arg2 = WDATA_IN;
            end else if (ADDR_IN == C_CMD) begin
                s_next.cmd = WDATA_IN;
                s_next.busy = 1'b1;
                s_next.timeout = 1'b0;
                s_next.poll_cnt = '0;
                s_next.step = 4'h0;
                s_next.state = HPEP_BUILD;
            end
        end
        if (WR_IN && ADDR_IN == C_STATUS) begin
            s_next.event_seen = s_next.event_seen & ~WDATA_IN[2];
            s_next.pps_seen = s_next.pps_seen & ~WDATA_IN[3];
            s_next.resp_seen = s_next.resp_seen & ~WDATA_IN[4];
        end
        // Register read mux
        if (ADDR_IN == C_STATUS) begin
            s_next.rd_data = {3'h0, s_reg.resp_seen, s_reg.pps_seen, s_reg.event_seen,
                              s_reg.timeout, s_reg.busy};
        end else if (ADDR_IN == C_CMD) begin
            s_next.rd_data = s_reg.cmd;
        end else if (ADDR_IN >= C_DATA0) begin
            s_next.rd_data = data_reg[ADDR_IN - C_DATA0];
        end else begin
            s_next.rd_data = 8'h00;
        end
        if (!RD_IN) begin
            s_next.rd_data = s_reg.rd_data;
        end
        case (s_reg.state)
            HPEP_IDLE: begin
            end
            HPEP_BUILD: begin
                s_next.ret = HPEP_BUILD;
                s_next.state = HPEP_BUSOP;
                s_next.bus.rd = 1'b0;
                s_next.bus.wr = 1'b1;
                s_next.bus_cnt = 5'h0;
                if (s_reg.cmd == CMD_GAIN || s_reg.cmd == CMD_OFFSET ||
                    s_reg.cmd == CMD_MODE) begin
                    s_next.plen = (s_reg.cmd == CMD_MODE) ? 4'h3 : 4'h5;
                    s_next.bus.addr = DEV_COMMAND_QUEUE_PORT;
                    if (s_reg.step == s_next.plen) begin
                        s_next.bus.wdata = PACKET_END_BYTE;
                    end else if (s_reg.step > s_next.plen) begin
                        s_next.bus.addr = DEV_HANDSHAKE_FLAGS;
                        s_next.bus.wdata = HS_PROCESS_CMD;
                        s_next.ret = HPEP_POLL;
                        s_next.poll_cnt = '0;
                    end else begin
                        s_next.bus.wdata = pkt_byte(s_reg.cmd, s_reg.step, s_reg.arg0,
                                                    s_reg.arg1, s_reg.arg2);
                    end
                    s_next.step = s_reg.step + 4'h1;
                end else if (s_reg.cmd == CMD_READ_TIME || s_reg.cmd == CMD_ARM_EVENT ||
                             s_reg.cmd == CMD_READ_EVENT) begin
                    s_next.bus.addr = DEV_BANK_SELECT;
                    s_next.bus.wdata = (s_reg.cmd == CMD_READ_TIME) ? BANK_ZERO : BANK_ONE;
                    s_next.step = 4'h0;
                    s_next.ret = HPEP_SEQ;
                end else if (s_reg.cmd == CMD_CLEAR_PPS) begin
                    s_next.bus.addr = DEV_INTERRUPT_FLAGS;
                    s_next.bus.wdata = IF_PPS_CLEAR;
                    s_next.ret = HPEP_DONE;
                end else if (s_reg.cmd == CMD_CLEAR_RESP) begin
                    s_next.bus.addr = DEV_HANDSHAKE_FLAGS;
                    s_next.bus.wdata = HS_RESP_CLEAR;
                    s_next.ret = HPEP_DONE;
                end else begin
                    s_next.state = HPEP_DONE;
                end
            end
            HPEP_SEQ: begin
                s_next.state = HPEP_BUSOP;
                s_next.bus_cnt = 5'h0;
                s_next.step = s_reg.step + 4'h1;
                s_next.bus.rd = 1'b1;
                s_next.bus.wr = 1'b0;
                s_next.ret = HPEP_READ;
                if (s_reg.cmd == CMD_READ_TIME) begin
                    s_next.bus.addr = DEV_LATCHED_TIME_FIRST + s_reg.step - 4'h1;
                    if (s_reg.step == 4'h0) begin
                        s_next.bus.addr = DEV_TIME_LATCH_REQUEST;
                    end
                    if (s_reg.step == 4'(TIME_REG_COUNT + 1)) begin
                        s_next.state = HPEP_DONE;
                    end
                end else if (s_reg.cmd == CMD_ARM_EVENT) begin
                    s_next.bus.rd = 1'b0;
                    s_next.bus.wr = 1'b1;
                    s_next.ret = HPEP_SEQ;
                    if (s_reg.step == 4'h0) begin
                        s_next.bus.addr = DEV_CONTROL_BANK1;
                        s_next.bus.wdata = CTRL_EVENT_LOCKOUT;
                    end else begin
                        s_next.bus.addr = DEV_INTERRUPT_FLAGS;
                        s_next.bus.wdata = IF_EVENT_CLEAR;
                        s_next.ret = HPEP_DONE;
                    end
                end else begin
                    if (s_reg.step == 4'h0) begin
                        s_next.bus.addr = DEV_INTERRUPT_FLAGS;
                        s_next.ret = HPEP_WAITEV;
                        s_next.step = 4'h0;
                    end else if (s_reg.step <= 4'(EVENT_REG_COUNT)) begin
                        s_next.bus.addr = DEV_EVENT_TIME_FIRST + s_reg.step - 4'h1;
                    end else if (s_reg.step == 4'(EVENT_REG_COUNT + 1)) begin
                        s_next.bus.addr = DEV_LOCKOUT_RELEASE;
                    end else begin
                        s_next.bus.rd = 1'b0;
                        s_next.bus.wr = 1'b1;
                        s_next.bus.addr = DEV_INTERRUPT_FLAGS;
                        s_next.bus.wdata = IF_EVENT_CLEAR;
                        s_next.ret = HPEP_DONE;
                    end
                end
            end
            HPEP_READ: begin
                // Lockout release read is not stored
                if (s_reg.step >= 4'h2 && s_reg.step <= 4'(EVENT_REG_COUNT + 1)) begin
                    data_we = 1'b1;
                    data_idx = s_reg.step - 4'h2;
                end
                s_next.state = HPEP_SEQ;
            end
            HPEP_WAITEV: begin
                s_next.poll_cnt = s_reg.poll_cnt + 18'h1;
                if (s_reg.rbyte[IF_EVENT_BIT]) begin
                    s_next.event_seen = 1'b1;
                    s_next.step = 4'h1;
                    s_next.state = HPEP_SEQ;
                end else if (s_reg.poll_cnt >= 18'(POLL_LIMIT_CYCLES)) begin
                    s_next.timeout = 1'b1;
                    s_next.state = HPEP_DONE;
                end else begin
                    s_next.step = 4'h0;
                    s_next.state = HPEP_SEQ;
                end
                if (s_reg.rbyte[IF_PPS_BIT]) begin
                    s_next.pps_seen = 1'b1;
                end
            end
            HPEP_POLL: begin
                s_next.poll_cnt = s_reg.poll_cnt + 18'h1;
                s_next.bus.rd = 1'b1;
                s_next.bus.wr = 1'b0;
                s_next.bus.addr = DEV_HANDSHAKE_FLAGS;
                s_next.bus_cnt = 5'h0;
                s_next.ret = HPEP_POLL;
                s_next.state = HPEP_BUSOP;
                if (s_reg.poll_cnt != 18'h0 && s_reg.rbyte[HS_ACK_BIT]) begin
                    s_next.resp_seen = s_reg.resp_seen | s_reg.rbyte[HS_RESP_BIT];
                    s_next.state = HPEP_DONE;
                end else if (s_reg.poll_cnt >= 18'(POLL_LIMIT_CYCLES)) begin
                    s_next.timeout = 1'b1;
                    s_next.state = HPEP_DONE;
                end
            end
            HPEP_BUSOP: begin
                // Setup, strobe, hold phases
                s_next.bus_cnt = s_reg.bus_cnt + 5'h1;
                s_next.dev_a = s_reg.bus.addr;
                s_next.dev_d_out = s_reg.bus.wdata;
                s_next.dev_d_oe = s_reg.bus.wr;
                s_next.dev_rd_n = !(s_reg.bus.rd && s_reg.bus_cnt >= 5'h1 &&
                                   s_reg.bus_cnt < 5'(BUS_CYCLES - 1));
                s_next.dev_wr_n = !(s_reg.bus.wr && s_reg.bus_cnt >= 5'h1 &&
                                   s_reg.bus_cnt < 5'(BUS_CYCLES - 1));
                if (s_reg.bus_cnt == 5'(BUS_CYCLES - 1)) begin
                    s_next.rbyte = d_sync_reg;
                end
                if (s_reg.bus_cnt == 5'(BUS_CYCLES + 1)) begin
                    s_next.dev_d_oe = 1'b0;
                    s_next.state = s_reg.ret;
                end
            end
            HPEP_DONE: begin
                s_next.busy = 1'b0;
                s_next.state = HPEP_IDLE;
            end
            default: begin
                s_next.state = HPEP_IDLE;
            end
        endcase
        if (!RSTN_IN) begin
            s_next = '0;
            s_next.state = HPEP_IDLE;
            s_next.ret = HPEP_IDLE;
            s_next.dev_rd_n = 1'b1;
            s_next.dev_wr_n = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        s_reg <= s_next;
        if (data_we && RSTN_IN) begin
            data_reg[data_idx] <= s_reg.rbyte;
        end
    end

    assign RDATA_OUT = s_reg.rd_data;
    assign DEV_A_OUT = s_reg.dev_a;
    assign DEV_D_OUT = s_reg.dev_d_out;
    assign DEV_D_OE_OUT = s_reg.dev_d_oe;
    assign DEV_RD_N_OUT = s_reg.dev_rd_n;
    assign DEV_WR_N_OUT = s_reg.dev_wr_n;
endmodule

/* File: hpep_ctrl_assertions.sv */
// Concurrent checks on the device-side pins of the controller
`timescale 1ns/10ps
module hpep_ctrl_checker
    import hpep_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [3:0] DEV_A_OUT,
    input wire logic [7:0] DEV_D_OUT,
    input wire logic DEV_D_OE_OUT,
    input wire logic DEV_RD_N_OUT,
    input wire logic DEV_WR_N_OUT
);
    logic [7:0] last_q_reg;
    logic open_reg;

    // Last queue byte and whether a packet is still open
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            last_q_reg <= 8'h00;
            open_reg <= 1'b0;
        end else if ($fell(DEV_WR_N_OUT) && DEV_A_OUT == DEV_COMMAND_QUEUE_PORT) begin
            last_q_reg <= DEV_D_OUT;
            open_reg <= DEV_D_OUT != PACKET_END_BYTE;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    sequence s_wr_low;
        !DEV_WR_N_OUT [*3] ##1 DEV_WR_N_OUT;
    endsequence
    sequence s_rd_low;
        !DEV_RD_N_OUT [*3] ##1 DEV_RD_N_OUT;
    endsequence

    a_strobe_excl: assert property (DEV_RD_N_OUT || DEV_WR_N_OUT)
        else $error("read and write strobes low together");
    a_write_drives: assert property (!DEV_WR_N_OUT |-> DEV_D_OE_OUT)
        else $error("write strobe without data drive");
    a_read_released: assert property (!DEV_RD_N_OUT |-> !DEV_D_OE_OUT)
        else $error("data driven during read");
    a_write_pulse: assert property ($fell(DEV_WR_N_OUT) |-> s_wr_low)
        else $error("write strobe length wrong");
    a_read_pulse: assert property ($fell(DEV_RD_N_OUT) |-> s_rd_low)
        else $error("read strobe length wrong");
    a_strobe_stable: assert property (!DEV_WR_N_OUT && !$past(DEV_WR_N_OUT)
        |-> $stable(DEV_A_OUT) && $stable(DEV_D_OUT))
        else $error("address or data moved in write");
    a_packet_start: assert property ($fell(DEV_WR_N_OUT) && !open_reg
        && DEV_A_OUT == DEV_COMMAND_QUEUE_PORT |-> DEV_D_OUT == PACKET_START_BYTE)
        else $error("packet not opened by start byte");
    a_process_after: assert property ($fell(DEV_WR_N_OUT) && DEV_A_OUT == DEV_HANDSHAKE_FLAGS
        && DEV_D_OUT == HS_PROCESS_CMD |-> last_q_reg == PACKET_END_BYTE && !open_reg)
        else $error("process command before end byte");
endmodule

bind hpep_ctrl hpep_ctrl_checker u_chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
    .DEV_A_OUT(DEV_A_OUT), .DEV_D_OUT(DEV_D_OUT), .DEV_D_OE_OUT(DEV_D_OE_OUT),
    .DEV_RD_N_OUT(DEV_RD_N_OUT), .DEV_WR_N_OUT(DEV_WR_N_OUT));

/* File: hpep_ctrl_test.sv */
// Self-checking bench for the host packet and event port controller
`timescale 1ns/10ps
module hpep_ctrl_test
    import hpep_pkg::*;
;
    logic clk, rstn, wr, rd, ev, pps, dev_oe, dev_rd_n, dev_wr_n;
    logic [3:0] addr, dev_a;
    logic [7:0] wdata, rdata, dev_d_in, dev_d_out;
    int failures = 0, num_checks = 0;

    hpep_ctrl DUT (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .DEV_A_OUT(dev_a), .DEV_D_IN(dev_d_in),
        .DEV_D_OUT(dev_d_out), .DEV_D_OE_OUT(dev_oe), .DEV_RD_N_OUT(dev_rd_n),
        .DEV_WR_N_OUT(dev_wr_n));
    hpep_dev_model dev (.a_in(dev_a), .d_in(dev_d_out), .rd_n_in(dev_rd_n),
        .wr_n_in(dev_wr_n), .ev_in(ev), .pps_in(pps), .d_out(dev_d_in));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic sw_wr(logic [3:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sw_rd(logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 5000; i++) begin
            sw_rd(C_STATUS, s);
            if (s[0] === 1'b0) return;
        end
        failures++;
        $display("BAD busy expected 0 seen 1");
    endtask
    task automatic run(logic [7:0] cmd);
        sw_wr(C_CMD, cmd);
        wait_idle();
    endtask
    task automatic chk_pkt(logic [7:0] e[]);
        chk("packet length", 8'(e.size()), 8'(dev.pkt.size()));
        foreach (e[i]) chk("packet byte", e[i], i < dev.pkt.size() ? dev.pkt[i] : 8'hxx);
    endtask
    task automatic chk_data(logic [7:0] e[8]);
        logic [7:0] d;
        foreach (e[i]) begin
            sw_rd(4'(C_DATA0 + i), d);
            chk("data byte", e[i], d);
        end
    endtask
    task automatic pulse(logic sel_pps);
        if (sel_pps)
            pps <= 1'b1;
        else
            ev <= 1'b1;
        @(posedge clk);
        {ev, pps} <= 2'b00;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_gain();
        logic [7:0] d;
        sw_wr(C_ARG0, 8'ha5);
        sw_wr(C_ARG1, 8'h00);
        run(CMD_GAIN);
        sw_rd(C_CMD, d);
        chk("command", CMD_GAIN, d);
        chk_pkt('{8'h01, 8'h51, 8'h35, 8'h41, 8'h30, 8'h17});
        sw_wr(C_ARG1, 8'h01);
        run(CMD_GAIN);
        chk_pkt('{8'h01, 8'h51, 8'h35, 8'h41, 8'h31, 8'h17});
    endtask
    task automatic t_offset();
        sw_wr(C_ARG0, 8'h05);
        sw_wr(C_ARG1, 8'h01);
        run(CMD_OFFSET);
        chk_pkt('{8'h01, 8'h52, 8'h2d, 8'h30, 8'h35, 8'h17});
        sw_wr(C_ARG0, 8'h12);
        sw_wr(C_ARG1, 8'h00);
        run(CMD_OFFSET);
        chk_pkt('{8'h01, 8'h52, 8'h2b, 8'h31, 8'h32, 8'h17});
    endtask
    task automatic t_mode();
        int n;
        dev.ack_dly = 300;
        for (int m = 0; m < 2; m++) begin
            n = dev.npkt;
            sw_wr(C_ARG0, 8'(m));
            sw_wr(C_CMD, CMD_MODE);
            sw_wr(C_CMD, CMD_GAIN);
            wait_idle();
            chk("packet count", 8'(n + 1), 8'(dev.npkt));
            chk_pkt('{8'h01, 8'h41, 8'(8'h30 + m), 8'h17});
        end
        dev.ack_dly = 4;
    endtask
    task automatic t_event();
        logic [7:0] cap[8];
        logic [7:0] s;
        run(CMD_ARM_EVENT);
        chk("bank", BANK_ONE, dev.bank);
        chk("control", CTRL_EVENT_LOCKOUT, dev.ctrl);
        pulse(1'b0);
        chk("event flag", 8'h01, {7'h00, dev.intf[IF_EVENT_BIT]});
        foreach (cap[i]) cap[i] = dev.ev[i];
        pulse(1'b0);
        run(CMD_READ_EVENT);
        chk_data(cap);
        chk("lockout", 8'h00, {7'h00, dev.locked});
        sw_rd(C_STATUS, s);
        chk("status", 8'h04, s);
        sw_wr(C_STATUS, 8'h04);
        sw_rd(C_STATUS, s);
        chk("status", 8'h00, s);
        chk("event flag", 8'h00, {7'h00, dev.intf[IF_EVENT_BIT]});
    endtask
    task automatic t_time();
        run(CMD_READ_TIME);
        chk("bank", BANK_ZERO, dev.bank);
        chk_data(dev.tm);
    endtask
    task automatic t_flags();
        pulse(1'b1);
        run(CMD_CLEAR_PPS);
        chk("pps flag", 8'h00, {7'h00, dev.intf[IF_PPS_BIT]});
        dev.hs[HS_RESP_BIT] = 1'b1;
        run(CMD_CLEAR_RESP);
        chk("resp flag", 8'h00, {7'h00, dev.hs[HS_RESP_BIT]});
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        logic [7:0] d;
        rstn <= 1'b0;
        {wr, rd, ev, pps, addr, wdata} <= '0;
        repeat (8) @(posedge clk);
        chk("idle strobes", 8'h03, {6'h00, dev_rd_n, dev_wr_n});
        chk("idle drive", 8'h00, {7'h00, dev_oe});
        chk("read data", 8'h00, rdata);
        rstn <= 1'b1;
        @(posedge clk);
        sw_rd(4'h5, d);
        chk("unmapped read", 8'h00, d);
        t_gain();
        t_offset();
        t_mode();
        t_event();
        t_time();
        t_flags();
        give_verdict();
    end
endmodule

/* File: hpep_dev_model.sv */
// Behavioural time processor device on the far side of the I/O page
`timescale 1ns/10ps
module hpep_dev_model
    import hpep_pkg::*;
(
    input wire logic [3:0] a_in,
    input wire logic [7:0] d_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic ev_in,
    input wire logic pps_in,
    output logic [7:0] d_out
);
    logic [7:0] bank = 8'h00, ctrl = 8'h00, hs = 8'h00, intf = 8'h00, last = 8'h00;
    logic [7:0] tick = 8'h00;
    logic [7:0] q[$], pkt[$], tm[8], ev[9];
    logic locked = 1'b0;
    int npkt = 0, ack_dly = 4;

    // Free-running time base
    always #5 tick = tick + 8'h01;
    function automatic logic [7:0] rdv(logic [3:0] a);
        if (a == DEV_HANDSHAKE_FLAGS) return hs;
        if (a == DEV_INTERRUPT_FLAGS) return intf;
        if (a == 4'h0 || a > 4'h9) return 8'h00;
        if (bank == BANK_ONE) return ev[a - 4'h1];
        return a < 4'h9 ? tm[a - 4'h1] : 8'h00;
    endfunction
    // Released bus shows inverse of last value
    assign d_out = rd_n_in ? ~last : rdv(a_in);
    always @(posedge rd_n_in) last = rdv(a_in);
    always @(negedge rd_n_in) begin
        if (a_in == DEV_TIME_LATCH_REQUEST && bank == BANK_ZERO)
            foreach (tm[i]) tm[i] = tick + 8'(i);
        if (a_in == DEV_LOCKOUT_RELEASE)
            locked = 1'b0;
    end
    always @(posedge wr_n_in) begin
        case (a_in)
            DEV_BANK_SELECT: bank = d_in;
            DEV_COMMAND_QUEUE_PORT: q.push_back(d_in);
            DEV_INTERRUPT_FLAGS: intf = intf & ~d_in;
            DEV_HANDSHAKE_FLAGS: hs = hs & ~d_in;
            DEV_CONTROL_BANK1: if (bank == BANK_ONE) ctrl = d_in;
            default: ;
        endcase
    end
    // queue acted on only after process command
    always @(posedge wr_n_in) begin
        if (a_in == DEV_HANDSHAKE_FLAGS && d_in == HS_PROCESS_CMD) begin
            #(ack_dly * 5);
            pkt = q;
            q = {};
            npkt++;
            hs[HS_ACK_BIT] = 1'b1;
        end
    end
    always @(posedge ev_in) begin
        if (ctrl == CTRL_EVENT_LOCKOUT && !locked) begin
            foreach (ev[i]) ev[i] = tick + 8'(i);
            locked = 1'b1;
            intf[IF_EVENT_BIT] = 1'b1;
        end
    end
    always @(posedge pps_in) intf[IF_PPS_BIT] = 1'b1;
endmodule

/* File: hpep_pkg.sv */
// Constants and types for the host packet and event port controller
// Operation
// - Frame packets with start 0x01, end 0x17
// - Gain packet: Q, low nibble, high nibble, sense
// - Offset: sign, hours tens, hours units
// - Bank select 0x00 time, 0x01 control
// - Event sets status bit 0; write 0x01 clears
// - After packet write 0x81 to handshake
// - Poll handshake bit 0 before next packet
// - PPS sets status bit 3; write 0x08 clears
// - Clear and await one-second flag before time set
// - Offset above 990 us: disable jam sync
// - Response pending bit 2; clear writing bit 2
package hpep_pkg;
    localparam logic [3:0] DEV_CONTROL_BANK1 = 4'h0;
    localparam logic [3:0] DEV_TIME_LATCH_REQUEST = 4'h0;
    localparam logic [3:0] DEV_EVENT_TIME_FIRST = 4'h1;
    localparam logic [3:0] DEV_LATCHED_TIME_FIRST = 4'h1;
    localparam logic [3:0] DEV_LOCKOUT_RELEASE = 4'ha;
    localparam logic [3:0] DEV_HANDSHAKE_FLAGS = 4'hb;
    localparam logic [3:0] DEV_INTERRUPT_FLAGS = 4'hd;
    localparam logic [3:0] DEV_COMMAND_QUEUE_PORT = 4'he;
    localparam logic [3:0] DEV_BANK_SELECT = 4'hf;
    localparam logic [7:0] PACKET_START_BYTE = 8'h01;
    localparam logic [7:0] PACKET_END_BYTE = 8'h17;
    localparam logic [7:0] BANK_ZERO = 8'h00;
    localparam logic [7:0] BANK_ONE = 8'h01;
    localparam logic [7:0] CTRL_EVENT_LOCKOUT = 8'h09;
    localparam logic [7:0] HS_PROCESS_CMD = 8'h81;
    localparam logic [7:0] HS_RESP_CLEAR = 8'h04;
    localparam int HS_ACK_BIT = 0;
    localparam int HS_RESP_BIT = 2;
    localparam logic [7:0] IF_EVENT_CLEAR = 8'h01;
    localparam logic [7:0] IF_PPS_CLEAR = 8'h08;
    localparam int IF_EVENT_BIT = 0;
    localparam int IF_PPS_BIT = 3;
    localparam int TIME_REG_COUNT = 8;
    localparam int EVENT_REG_COUNT = 9;
    localparam int MAX_BODY = 10;
    localparam logic [7:0] ID_GAIN = 8'h51;
    localparam logic [7:0] ID_OFFSET = 8'h52;
    localparam logic [7:0] ID_MODE = 8'h41;
    // Host-side register offsets of this controller
    localparam logic [3:0] C_CMD = 4'h0;
    localparam logic [3:0] C_STATUS = 4'h1;
    localparam logic [3:0] C_ARG0 = 4'h2;
    localparam logic [3:0] C_ARG1 = 4'h3;
    localparam logic [3:0] C_ARG2 = 4'h4;
    localparam logic [3:0] C_DATA0 = 4'h8;
    localparam logic [7:0] CMD_GAIN = 8'h01;
    localparam logic [7:0] CMD_OFFSET = 8'h02;
    localparam logic [7:0] CMD_MODE = 8'h03;
    localparam logic [7:0] CMD_READ_TIME = 8'h04;
    localparam logic [7:0] CMD_ARM_EVENT = 8'h05;
    localparam logic [7:0] CMD_READ_EVENT = 8'h06;
    localparam logic [7:0] CMD_CLEAR_PPS = 8'h07;
    localparam logic [7:0] CMD_CLEAR_RESP = 8'h08;
    // Bus cycle: one clock setup, three strobe, two hold
    localparam int BUS_NS = 25;
    localparam int BUS_CYCLES = (BUS_NS + 4) / 5;
    localparam int POLL_LIMIT_US = 1000;
    localparam int POLL_LIMIT_CYCLES = POLL_LIMIT_US * 200;

    typedef enum logic [8:0] {
        HPEP_IDLE = 9'h001, HPEP_BUILD = 9'h002, HPEP_WRITE = 9'h004,
        HPEP_POLL = 9'h008, HPEP_READ = 9'h010, HPEP_WAITEV = 9'h020,
        HPEP_SEQ = 9'h040, HPEP_DONE = 9'h080, HPEP_BUSOP = 9'h100
    } hpep_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } hpep_bus_t;

    typedef struct packed {
        hpep_state_t state;
        hpep_state_t ret;
        hpep_bus_t bus;
        logic [4:0] bus_cnt;
        logic [7:0] rbyte;
        logic [7:0] cmd;
        logic [7:0] arg0;
        logic [7:0] arg1;
        logic [7:0] arg2;
        logic [3:0] step;
        logic [3:0] plen;
        logic [17:0] poll_cnt;
        logic busy;
        logic timeout;
        logic event_seen;
        logic pps_seen;
        logic resp_seen;
        logic [7:0] rd_data;
        logic [7:0] dev_d_out;
        logic dev_d_oe;
        logic dev_rd_n;
        logic dev_wr_n;
        logic [3:0] dev_a;
    } hpep_st_t;
endpackage
